/* File: hw/fra_params.svh */
/*
 * Constants of the flash register access block: opcodes, bit positions,
 * reset values and the register write time.
 * Assumes it is included by bare name and that the clock runs at 250 MHz.
 */
`ifndef FRA_PARAMS_SVH
`define FRA_PARAMS_SVH

// ****************************************
// Opcodes
// ****************************************
`define FRA_OP_UNIQUE_ID 8'h4C
`define FRA_OP_STATUS1 8'h05
`define FRA_OP_STATUS2 8'h07
`define FRA_OP_CONFIG1 8'h35
`define FRA_OP_CONFIG2 8'h15
`define FRA_OP_CONFIG3 8'h33
`define FRA_OP_REG_WRITE 8'h01
`define FRA_OP_WRITE_ENABLE 8'h06
`define FRA_OP_CLEAR_STATUS 8'h30

// ****************************************
// Field positions
// ****************************************
`define FRA_WIP_BIT 0
`define FRA_WEL_BIT 1
`define FRA_LOCK_BIT 7
`define FRA_PERR_BIT 5
`define FRA_EERR_BIT 6
`define FRA_QUAD_BIT 1
`define FRA_QPI_BIT 3
`define FRA_RLC_HI 5
`define FRA_RLC_LO 4

// ****************************************
// Reset values and timing
// ****************************************
`define FRA_REG_RESET 8'h00
// Arbitrary value, stands for the factory-set identifier
`define FRA_UID_DEFAULT 64'h0123456789ABCDEF
`define FRA_UID_DUMMY 4'h8
`define FRA_CLK_PERIOD_NS 4
`define FRA_WRITE_TIME_NS 2000
`define FRA_WRITE_CYCLES ((`FRA_WRITE_TIME_NS + `FRA_CLK_PERIOD_NS - 1) / `FRA_CLK_PERIOD_NS)

`endif

/* File: hw/fra_pkg.sv */
/*
 * Types of the flash register access block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fra_pkg;

	typedef enum logic [2:0] {
		FRA_IDLE,
		FRA_OPCODE,
		FRA_DUMMY,
		FRA_READ,
		FRA_WDATA,
		FRA_SKIP
	} fra_state_t;

	typedef struct packed {
		logic [7:0] status1;
		logic [7:0] status2;
		logic [7:0] config1;
		logic [7:0] config2;
		logic [7:0] config3;
	} fra_regs_t;

	typedef struct packed {
		logic [3:0] data;
		logic [3:0] oe;
	} fra_lanes_t;

endpackage

/* File: hw/fra_core.sv */
/*
 * Register access command interpreter of a serial flash: unique-ID read,
 * status and configuration reads, write enable, clear status, register write.
 * Assumes SPI mode 0 or 3 with SCK well below a quarter of I_CLK; all pins
 * are asynchronous to I_CLK and are synchronised here.
 */
// Notes on behaviour
// - Unique-ID opcode: 8 dummy clocks, then 8 identifier bytes on output lane, or on four lanes in quad command mode.
// - Identifier is a fixed read-only 64-bit value; no command changes it.
// - Clocking past the last identifier byte wraps to byte 0.
// - Chip select high ends the read and stops driving data.
// - Register opcodes take data or latency directly, no address phase.
// - Status 1 read returns volatile status 1 at any time, even busy.
// - Repeated status reads refresh the value every byte: eight clocks, or two in quad command mode.
// - Latency before register read data comes from config 3 bits 5:4.
// - Status 2 read works any time; quad command mode uses four lanes.
// - Config reads return config 1, 2, 3, repeating every byte (eight clocks, two in quad command mode).
// - Register write accepted only with write-enable latch set.
// - Write updates volatile registers at once, then non-volatile copies.
// - Write executes only after exactly 8, 16, 24 or 32 data bits.
// - Byte count picks targets: status 1, then config 1, 2, 3.
// - Failed write sets error flag and stays busy until clear status.
// - Write starts on chip select rise; in-progress flag 1 meanwhile.
// - Finished register write clears the write-enable latch.
// - Lock bit zero: enabled writes proceed regardless of protect pin.
// - Lock bit one and protect pin low: write silently dropped.
// - Protection ignored in quad mode or quad command mode.
// - Write-enable opcode sets the write-enable latch, status 1 bit 1, when not busy.
// - Clear status clears busy and error flags unless a write fails in the same cycle, keeps latch, works busy.
`timescale 1ns/10ps
`include "fra_params.svh"

module fra_core (
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST_N,
	// Serial link pins
	input wire logic I_CS_N,
	input wire logic I_SCK,
	input wire logic [3:0] I_IO,
	output fra_pkg::fra_lanes_t O_LANES,
	// Internal status
	input wire logic I_WRITE_FAIL,
	output fra_pkg::fra_regs_t O_VOLATILE,
	output fra_pkg::fra_regs_t O_NONVOLATILE
);

	localparam logic [63:0] UNIQUE_ID = `FRA_UID_DEFAULT;
	localparam logic [15:0] WRITE_CYCLES = 16'(`FRA_WRITE_CYCLES);

	// ****************************************
	// Synchronisers and edges
	// ****************************************
	logic [2:0] sck_sy;
	logic [2:0] cs_sy;
	logic [3:0] io_meta;
	logic [3:0] io_s;
	logic sck_rise;
	logic sck_fall;
	logic cs_n;
	logic cs_rise;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sck_sy <= 3'h0;
			cs_sy <= 3'h7;
			io_meta <= 4'h0;
			io_s <= 4'h0;
		end else begin
			sck_sy <= {sck_sy[1:0], I_SCK};
			cs_sy <= {cs_sy[1:0], I_CS_N};
			io_meta <= I_IO;
			io_s <= io_meta;
		end
	end

	assign sck_rise = sck_sy[1] & ~sck_sy[2];
	assign sck_fall = ~sck_sy[1] & sck_sy[2];
	assign cs_n = cs_sy[1];
	assign cs_rise = cs_sy[1] & ~cs_sy[2];

	// ****************************************
	// Command sequencer
	// ****************************************
	fra_pkg::fra_state_t state;
	fra_pkg::fra_regs_t vol;
	fra_pkg::fra_regs_t nv;
	logic [7:0] opcode;
	logic [7:0] cmd;
	logic [5:0] cnt;
	logic [3:0] dummy;
	logic [7:0] tx;
	logic [2:0] txpos;
	logic [2:0] uid_idx;
	logic [5:0] wcnt;
	logic [7:0] wcur;
	logic [7:0] wbytes [0:3];
	logic quad_cmd;
	logic [7:0] next_opcode;
	logic [7:0] next_wcur;
	logic [3:0] rlc_dummy;
	logic [2:0] last_pos;
	logic busy;

	assign quad_cmd = vol.config2[`FRA_QPI_BIT];
	assign busy = vol.status1[`FRA_WIP_BIT];
	assign next_opcode = quad_cmd ? {opcode[3:0], io_s} : {opcode[6:0], io_s[0]};
	assign next_wcur = quad_cmd ? {wcur[3:0], io_s} : {wcur[6:0], io_s[0]};
	assign rlc_dummy = {2'b00, vol.config3[`FRA_RLC_HI:`FRA_RLC_LO]};
	assign last_pos = quad_cmd ? 3'h1 : 3'h7;

	function automatic logic [7:0] uid_byte(input logic [2:0] idx);
		uid_byte = UNIQUE_ID[{idx, 3'b000} +: 8];
	endfunction

	// Register reads take the live value, so each byte is a fresh sample
	function automatic logic [7:0] read_byte(input logic [7:0] op,
		input fra_pkg::fra_regs_t r, input logic [2:0] idx);
		case (op)
			`FRA_OP_UNIQUE_ID: read_byte = uid_byte(idx);
			`FRA_OP_STATUS1: read_byte = r.status1;
			`FRA_OP_STATUS2: read_byte = r.status2;
			`FRA_OP_CONFIG1: read_byte = r.config1;
			`FRA_OP_CONFIG2: read_byte = r.config2;
			`FRA_OP_CONFIG3: read_byte = r.config3;
			default: read_byte = 8'h00;
		endcase
	endfunction

	function automatic logic is_reg_read(input logic [7:0] op);
		is_reg_read = (op == `FRA_OP_STATUS1) || (op == `FRA_OP_STATUS2) ||
			(op == `FRA_OP_CONFIG1) || (op == `FRA_OP_CONFIG2) || (op == `FRA_OP_CONFIG3);
	endfunction

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state <= fra_pkg::FRA_IDLE;
			opcode <= 8'h00;
			cmd <= 8'h00;
			cnt <= 6'h00;
			dummy <= 4'h0;
			tx <= 8'h00;
			txpos <= 3'h0;
			uid_idx <= 3'h0;
			wcnt <= 6'h00;
			wcur <= 8'h00;
			for (int i = 0; i < 4; i++) begin
				wbytes[i] <= 8'h00;
			end
		end else if (cs_n) begin
			state <= fra_pkg::FRA_IDLE;
		end else if (state == fra_pkg::FRA_IDLE) begin
			state <= fra_pkg::FRA_OPCODE;
			cnt <= 6'h00;
			wcnt <= 6'h00;
		end else if (sck_rise) begin
			unique case (state)
				fra_pkg::FRA_OPCODE: begin
					opcode <= next_opcode;
					cnt <= cnt + 6'h01;
					if (cnt[2:0] == last_pos) begin
						cmd <= next_opcode;
						cnt <= 6'h00;
						tx <= read_byte(next_opcode, vol, 3'h0);
						txpos <= 3'h0;
						uid_idx <= 3'h0;
						// Address phase never follows these opcodes
						if (next_opcode == `FRA_OP_UNIQUE_ID) begin
							dummy <= `FRA_UID_DUMMY;
							state <= fra_pkg::FRA_DUMMY;
						end else if (is_reg_read(next_opcode)) begin
							dummy <= rlc_dummy;
							state <= (rlc_dummy == 4'h0) ? fra_pkg::FRA_READ : fra_pkg::FRA_DUMMY;
						end else if (next_opcode == `FRA_OP_REG_WRITE && !busy) begin
							state <= fra_pkg::FRA_WDATA;
						end else begin
							state <= fra_pkg::FRA_SKIP;
						end
					end
				end
				fra_pkg::FRA_DUMMY: begin
					// Lane values are ignored here
					cnt <= cnt + 6'h01;
					if (cnt[3:0] == dummy - 4'h1) begin
						state <= fra_pkg::FRA_READ;
						tx <= read_byte(cmd, vol, 3'h0);
					end
				end
				fra_pkg::FRA_READ: begin
					cnt <= cnt;
				end
				fra_pkg::FRA_WDATA: begin
					wcur <= next_wcur;
					if (wcnt <= 6'd32) begin
						wcnt <= wcnt + (quad_cmd ? 6'h04 : 6'h01);
					end
					if (wcnt[2:0] == (quad_cmd ? 3'h4 : 3'h7) && wcnt < 6'd32) begin
						wbytes[wcnt[4:3]] <= next_wcur;
					end
				end
				fra_pkg::FRA_SKIP: begin
					if (cnt != 6'h3F) begin
						cnt <= cnt + 6'h01;
					end
				end
				default: state <= fra_pkg::FRA_IDLE;
			endcase
		end else if (sck_fall && state == fra_pkg::FRA_READ) begin
			if (txpos == last_pos) begin
				txpos <= 3'h0;
				uid_idx <= uid_idx + 3'h1;
				tx <= read_byte(cmd, vol, uid_idx + 3'h1);
			end else begin
				txpos <= txpos + 3'h1;
			end
		end
	end

	// ****************************************
	// Output lanes
	// ****************************************
	fra_pkg::fra_lanes_t lanes;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lanes <= '0;
		end else if (cs_n || state != fra_pkg::FRA_READ) begin
			lanes <= '0;
		end else if (sck_fall) begin
			if (quad_cmd) begin
				lanes.oe <= 4'hF;
				lanes.data <= (txpos == 3'h0) ? tx[7:4] : tx[3:0];
			end else begin
				lanes.oe <= 4'h2;
				lanes.data <= {2'b00, tx[3'h7 - txpos], 1'b0};
			end
		end
	end

	assign O_LANES = lanes;

	// ****************************************
	// Register bank and write timer
	// ****************************************
	logic exec_ok;
	logic ev_write_enable_cmd;
	logic ev_clear;
	logic wrr_try;
	logic count_ok;
	logic locked;
	logic ev_wrr;
	logic busy_run;
	logic [15:0] timer;
	logic [2:0] pend_n;
	logic fail_now;

	assign exec_ok = cs_rise && state == fra_pkg::FRA_SKIP && cnt == 6'h00;
	assign ev_write_enable_cmd = exec_ok && cmd == `FRA_OP_WRITE_ENABLE && !busy;
	assign ev_clear = exec_ok && cmd == `FRA_OP_CLEAR_STATUS;
	assign wrr_try = cs_rise && state == fra_pkg::FRA_WDATA;
	assign count_ok = wcnt[2:0] == 3'h0 && wcnt != 6'h00 && wcnt <= 6'd32;
	// Protect pin doubles as a data lane in either quad mode
	assign locked = vol.status1[`FRA_LOCK_BIT] && !io_s[2] &&
		!(vol.config1[`FRA_QUAD_BIT] || quad_cmd);
	assign ev_wrr = wrr_try && count_ok && vol.status1[`FRA_WEL_BIT] && !locked;
	assign fail_now = busy_run && timer == 16'h0000 && I_WRITE_FAIL;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			vol <= {5{`FRA_REG_RESET}};
			nv <= {5{`FRA_REG_RESET}};
			busy_run <= 1'b0;
			timer <= 16'h0000;
			pend_n <= 3'h0;
		end else if (ev_clear) begin
			// A failure in the same cycle wins, so the error is never lost
			vol.status1[`FRA_WIP_BIT] <= fail_now;
			vol.status2[`FRA_PERR_BIT] <= fail_now;
			vol.status2[`FRA_EERR_BIT] <= 1'b0;
			busy_run <= 1'b0;
		end else if (ev_wrr) begin
			// Hardware owns the latch and busy bits
			vol.status1 <= {wbytes[0][7:2], 1'b1, 1'b1};
			if (wcnt[5:3] >= 3'h2) begin
				vol.config1 <= wbytes[1];
			end
			if (wcnt[5:3] >= 3'h3) begin
				vol.config2 <= wbytes[2];
			end
			if (wcnt[5:3] == 3'h4) begin
				vol.config3 <= wbytes[3];
			end
			pend_n <= wcnt[5:3];
			busy_run <= 1'b1;
			timer <= WRITE_CYCLES - 16'h0001;
		end else if (ev_write_enable_cmd) begin
			vol.status1[`FRA_WEL_BIT] <= 1'b1;
		end else if (busy_run) begin
			if (timer != 16'h0000) begin
				timer <= timer - 16'h0001;
			end else if (I_WRITE_FAIL) begin
				busy_run <= 1'b0;
				vol.status2[`FRA_PERR_BIT] <= 1'b1;
			end else begin
				busy_run <= 1'b0;
				vol.status1[`FRA_WIP_BIT] <= 1'b0;
				vol.status1[`FRA_WEL_BIT] <= 1'b0;
				nv.status1 <= {vol.status1[7:2], 2'b00};
				nv.config1 <= (pend_n >= 3'h2) ? vol.config1 : nv.config1;
				nv.config2 <= (pend_n >= 3'h3) ? vol.config2 : nv.config2;
				nv.config3 <= (pend_n == 3'h4) ? vol.config3 : nv.config3;
			end
		end
	end

	assign O_VOLATILE = vol;
	assign O_NONVOLATILE = nv;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_write_start;
		ev_wrr;
	endsequence

	sequence s_write_busy;
		(busy && busy_run) [*2];
	endsequence

	uid_dummy_end_a: assert property (
		!cs_n && sck_rise && state == fra_pkg::FRA_DUMMY && cmd == `FRA_OP_UNIQUE_ID
		&& cnt == 6'h07 |=> state == fra_pkg::FRA_READ && tx == uid_byte(3'h0))
		else $error("unique id did not start after eight dummy clocks");

	uid_wrap_a: assert property (
		!cs_n && sck_fall && state == fra_pkg::FRA_READ && cmd == `FRA_OP_UNIQUE_ID
		&& txpos == last_pos && uid_idx == 3'h7 |=> uid_idx == 3'h0 && tx == uid_byte(3'h0))
		else $error("unique id did not wrap to byte zero");

	cs_release_a: assert property (cs_n |=> O_LANES.oe == 4'h0)
		else $error("lanes still driven after chip select rise");

	status_refresh_a: assert property (
		!cs_n && sck_fall && state == fra_pkg::FRA_READ && cmd == `FRA_OP_STATUS1
		&& txpos == last_pos |=> tx == $past(vol.status1))
		else $error("status byte not refreshed at byte boundary");

	write_enable_cmd_sets_a: assert property (ev_write_enable_cmd |=> vol.status1[`FRA_WEL_BIT])
		else $error("write enable did not set latch");

	clear_status_a: assert property (ev_clear |=> busy == $past(fail_now) &&
		vol.status2[`FRA_PERR_BIT] == $past(fail_now) && !vol.status2[`FRA_EERR_BIT]
		&& vol.status1[`FRA_WEL_BIT] == $past(vol.status1[`FRA_WEL_BIT]))
		else $error("clear status left flags or changed latch");

	bad_count_a: assert property (
		wrr_try && !count_ok |=> $stable(vol.config1) && $stable(vol.config3) && !busy_run)
		else $error("write with bad bit count was executed");

	lock_reject_a: assert property (
		wrr_try && locked |=> !busy_run && $stable(vol.status2) && $stable(vol.config1))
		else $error("locked write was not silently rejected");

	write_busy_a: assert property (s_write_start |=> s_write_busy)
		else $error("write in progress flag not set for write");

	write_done_a: assert property (
		!ev_clear && busy_run && timer == 16'h0000 && !I_WRITE_FAIL
		|=> !busy && !vol.status1[`FRA_WEL_BIT])
		else $error("finished write left latch or busy set");

	write_fail_a: assert property (
		busy_run && timer == 16'h0000 && I_WRITE_FAIL
		|=> busy && vol.status2[`FRA_PERR_BIT] ##1 busy || $past(ev_clear))
		else $error("failed write did not hang busy with error");

	quiet_phase_a: assert property (
		state == fra_pkg::FRA_OPCODE || state == fra_pkg::FRA_DUMMY |=> O_LANES.oe == 4'h0)
		else $error("lanes driven during opcode or dummy phase");

endmodule

/* File: sim/fra_host.sv */
/*
 * Behavioural host controller for the serial link: single or four lane frames, mode 0.
 * Assumes I_CLK at 250 MHz; one SCK period is 16 clocks (64 ns).
 */
`timescale 1ns/10ps

module fra_host (
	// Clock and protect level
	input wire logic i_clk,
	input wire logic i_wp,
	// Link pins
	input wire fra_pkg::fra_lanes_t i_lanes,
	output logic o_cs_n = 1'b1,
	output logic o_sck = 1'b0,
	output wire logic [3:0] o_io
);
	logic tog = 1'b0;
	logic drv = 1'b0;
	logic qmode = 1'b0;
	logic [3:0] nib = 4'h0;

	// Undriven lanes toggle so a stale value never reads as valid
	always @(posedge i_clk) begin
		tog <= ~tog;
	end
	// Protect level sits on lane 2 only while frames are single lane
	assign o_io = qmode ? (drv ? nib : {4{tog}}) :
		{1'b1, i_wp, tog, drv ? nib[3] : tog};

	// ****************************************
	// One frame: opcode, write bits or dummies, read bits; q selects four lanes
	// ****************************************
	task automatic frame(input logic [7:0] op, input logic [31:0] wd, input int nw,
		input int nd, input int nr, input logic q, output logic [71:0] rd, output logic bad);
		logic [39:0] sh;
		int n;
		int k;
		sh = {op, wd};
		rd = '0;
		bad = 1'b0;
		n = q ? (8 + nw) / 4 : 8 + nw;
		k = n + nd + (q ? nr / 4 : nr);
		qmode <= q;
		o_cs_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		for (int i = 0; i < k; i++) begin
			drv <= (i < n);
			nib <= sh[39:36];
			sh = q ? {sh[35:0], 4'h0} : {sh[38:0], 1'b0};
			o_sck <= 1'b0;
			repeat (8) @(posedge i_clk);
			if (i >= n + nd) begin
				rd = q ? {rd[67:0], i_lanes.data} : {rd[70:0], i_lanes.data[1]};
				bad = bad | (i_lanes.oe !== (q ? 4'hF : 4'h2));
			end else if (i_lanes.oe !== 4'h0) begin
				bad = 1'b1;
			end
			o_sck <= 1'b1;
			repeat (8) @(posedge i_clk);
		end
		o_sck <= 1'b0;
		drv <= 1'b0;
		repeat (8) @(posedge i_clk);
		o_cs_n <= 1'b1;
		repeat (8) @(posedge i_clk);
	endtask
endmodule

/* File: sim/flash_register_access_commands_tb.sv */
/*
 * Self-checking bench of the register access command block.
 * Assumes fra_core, fra_pkg and the host model are compiled first.
 */
`timescale 1ns/10ps
`include "fra_params.svh"

module flash_register_access_commands_tb;
	logic I_CLK = 1'b0;
	logic I_RST_N = 1'b0;
	logic I_WRITE_FAIL = 1'b0;
	logic wp = 1'b0;
	logic cs_n;
	logic sck;
	logic [3:0] io;
	fra_pkg::fra_lanes_t lanes;
	fra_pkg::fra_regs_t vol;
	fra_pkg::fra_regs_t nv;
	int fails = 0;
	int checks = 0;
	logic [71:0] rd;
	logic bad;
	logic quad = 1'b0;

	always #2 I_CLK = ~I_CLK;

	fra_core fra_core_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CS_N(cs_n), .I_SCK(sck),
		.I_IO(io), .O_LANES(lanes), .I_WRITE_FAIL(I_WRITE_FAIL), .O_VOLATILE(vol),
		.O_NONVOLATILE(nv));
	fra_host fra_host_inst (.i_clk(I_CLK), .i_wp(wp), .i_lanes(lanes), .o_cs_n(cs_n),
		.o_sck(sck), .o_io(io));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (fails == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic cmd(input logic [7:0] op, input logic [31:0] wd, input int nw,
		input int nd, input int nr);
		fra_host_inst.frame(op, wd, nw, nd, nr, quad, rd, bad);
	endtask

	task automatic settle();
		int n;
		n = 0;
		while (vol.status1[0] !== 1'b0 && n < 700) begin
			@(posedge I_CLK);
			n++;
		end
		if (n >= 700) begin
			fails++;
			close_out();
		end
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_uid();
		logic [63:0] u;
		logic [71:0] e;
		u = `FRA_UID_DEFAULT;
		e = '0;
		for (int i = 0; i < 9; i++) begin
			e = {e[63:0], u[8 * (i % 8) +: 8]};
		end
		cmd(`FRA_OP_UNIQUE_ID, 32'h0, 0, 8, 72);
		chk(rd, e);
		chk(bad, 1'b0);
		cmd(`FRA_OP_UNIQUE_ID, 32'h0, 0, 8, 20);
		chk(lanes.oe, 4'h0);
	endtask

	task automatic t_write();
		logic [7:0] ops [5];
		logic [7:0] exps [5];
		ops = '{`FRA_OP_STATUS1, `FRA_OP_STATUS2, `FRA_OP_CONFIG1, `FRA_OP_CONFIG2,
			`FRA_OP_CONFIG3};
		exps = '{8'h1C, 8'h00, 8'h20, 8'h40, 8'h10};
		cmd(`FRA_OP_REG_WRITE, 32'h1C204010, 32, 0, 0);
		chk(vol, 40'h0);
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		chk(vol.status1, 8'h02);
		cmd(`FRA_OP_REG_WRITE, 32'h1C204010, 32, 0, 0);
		chk(vol, 40'h1F00204010);
		cmd(`FRA_OP_STATUS1, 32'h0, 0, 1, 16);
		chk(rd[15:0], 16'h1F1F);
		settle();
		chk(vol.status1, 8'h1C);
		chk(nv, 40'h1C00204010);
		for (int i = 0; i < 5; i++) begin
			cmd(ops[i], 32'h0, 0, 1, 16);
			chk(rd[15:0], {exps[i], exps[i]});
			chk(bad, 1'b0);
		end
	endtask

	task automatic t_count();
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'hABC00000, 12, 0, 0);
		chk(vol.status1, 8'h1E);
		cmd(`FRA_OP_REG_WRITE, 32'h80000000, 8, 0, 0);
		chk(vol, 40'h8300204010);
		settle();
	endtask

	task automatic t_lock();
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h00000000, 8, 0, 0);
		chk(vol, 40'h8200204010);
		wp <= 1'b1;
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h80020000, 16, 0, 0);
		settle();
		chk({vol.status1, vol.config1}, 16'h8002);
		wp <= 1'b0;
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h00000000, 16, 0, 0);
		settle();
		chk({vol.status1, vol.config1}, 16'h0000);
	endtask

	task automatic t_fail();
		I_WRITE_FAIL <= 1'b1;
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h04000000, 8, 0, 0);
		repeat (520) @(posedge I_CLK);
		chk({vol.status1, vol.status2}, 16'h0720);
		cmd(`FRA_OP_STATUS2, 32'h0, 0, 1, 8);
		chk(rd[7:0], 8'h20);
		I_WRITE_FAIL <= 1'b0;
		cmd(`FRA_OP_CLEAR_STATUS, 32'h0, 0, 0, 0);
		chk({vol.status1, vol.status2}, 16'h0600);
	endtask

	task automatic t_quad();
		logic [63:0] u;
		logic [63:0] e;
		u = `FRA_UID_DEFAULT;
		for (int i = 0; i < 8; i++) begin
			e[63 - 8 * i -: 8] = u[8 * i +: 8];
		end
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h00000800, 24, 0, 0);
		settle();
		quad = 1'b1;
		cmd(`FRA_OP_CONFIG2, 32'h0, 0, 1, 16);
		chk(rd[15:0], 16'h0808);
		chk(bad, 1'b0);
		cmd(`FRA_OP_STATUS2, 32'h0, 0, 1, 16);
		chk({rd[15:0], bad}, 17'h0);
		cmd(`FRA_OP_UNIQUE_ID, 32'h0, 0, 8, 64);
		chk(rd[63:0], e);
		chk(bad, 1'b0);
		cmd(`FRA_OP_WRITE_ENABLE, 32'h0, 0, 0, 0);
		cmd(`FRA_OP_REG_WRITE, 32'h00000000, 24, 0, 0);
		chk(vol.config2, 8'h00);
		settle();
		quad = 1'b0;
		cmd(`FRA_OP_CONFIG2, 32'h0, 0, 1, 8);
		chk({rd[7:0], bad}, 9'h0);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		repeat (2) @(posedge I_CLK);
		I_RST_N <= 1'b1;
		repeat (3) @(posedge I_CLK);
		chk(vol, 40'h0);
		chk({nv, lanes}, 48'h0);
		t_uid();
		t_write();
		t_count();
		t_lock();
		t_fail();
		t_quad();
		close_out();
	end
endmodule
